//--- rtl/rtdp_datapath.sv
// Transmit datapath: byte FIFO, framing, bit shifter, event pins, ref clock.
//
// Operation
// R1: Data-mode bit 0 selects continuous mode; bits sampled on bit clock rise.
// R2: Host changes continuous data on bit clock fall; clock optional in OOK.
// R3: Buffered mode stores bytes in 64-byte FIFO feeding a bit shifter.
// R4: Start-condition bit picks start at first byte or at fill point.
// R5: FIFO-full flag is high whenever FIFO holds full capacity.
// R6: Write while full sets overrun and overwrites oldest contents.
// R7: Writing one to overrun clears it and empties the FIFO.
// R8: Not-empty drops when last byte moves into the shift register.
// R9: Transmit-stopped rises as the final bit starts with nothing queued.
// R10: Host stays in transmit one bit period after transmit-stopped.
// R11: Leaving transmit stops at once, abandoning shift register bits.
// R12: Pin B in transmit: full or stopped by select; bit clock continuous.
// R13: Pin A in transmit: zero continuous; threshold or not-empty otherwise.
// R14: Pin A in receive follows the selected source per data mode.
// R15: Pin B in receive: bit clock continuous, else selected source.
// R16: Reference output driven only while its enable bit is one.
// R17: Reference output is crystal clock divided by five-bit field ratio.
// R18: Reference output stopped during sleep regardless of enable.
// R19: Packet handling works only with packet-handler enable set.
// R20: Length format bit: zero fixed length, one variable length.
// R21: Fixed length field gives payload bytes including address byte.
// R22: Packet order: preamble, start pattern, payload, optional two-byte CRC.
// R23: Start at first byte, or when count reaches programmed threshold.
// R24: Transmit threshold event active while count at or below threshold.
// R25: Bytes shift out most significant bit first, one bit per period.

`include "rtdp_params.svh"

// ------------------------------------------------------------
// Byte FIFO with flush and overwrite-on-full
// ------------------------------------------------------------
module rtdp_fifo
   import rtdp_pkg::*;
#(
   parameter int WIDTH = `RTDP_BYTE_W,
   parameter int DEPTH = `RTDP_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic in_force,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH-1);
   localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [LW-1:0] level_ff;
   logic full;
   logic push;
   logic pop;

   assign full = (level_ff == FULL_LVL);
   assign in_ready = !full;
   assign out_valid = (level_ff != '0);
   assign out_data = mem_ff[rd_ptr_ff];
   assign level = level_ff;
   assign push = in_valid && (!full || in_force);
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else if (flush) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == LAST_IDX) ? '0 : wr_ptr_ff + 1'b1;
         end
         // A write into a full FIFO drops the oldest entry.
         if (pop || (push && full)) begin
            rd_ptr_ff <= (rd_ptr_ff == LAST_IDX) ? '0 : rd_ptr_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_ff <= '0;
      end else if (flush) begin
         level_ff <= '0;
      end else if (push && !pop && !full) begin
         level_ff <= level_ff + 1'b1;
      end else if (pop && !push) begin
         level_ff <= level_ff - 1'b1;
      end
   end
endmodule

// ------------------------------------------------------------
// Top level
// ------------------------------------------------------------
module rtdp_datapath
   import rtdp_pkg::*;
#(
   parameter int DEPTH = `RTDP_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tx_mode,
   input wire logic rx_mode,
   input wire logic sleep_mode,
   input wire logic data_mode_select_bit,
   input wire logic packet_handler_enable_bit,
   input wire logic packet_length_format_bit,
   input wire logic [`RTDP_LEN_W-1:0] payload_length_field,
   input wire logic crc_enable_bit,
   input wire logic [1:0] preamble_len_field,
   input wire logic [15:0] start_pattern_word,
   input wire logic [15:0] crc_word,
   input wire logic tx_start_condition_bit,
   input wire logic [`RTDP_THRESH_W-1:0] fifo_level_threshold,
   input wire logic tx_pin_a_select,
   input wire logic tx_pin_b_select,
   input wire logic [1:0] rx_pin_a_select,
   input wire logic [1:0] rx_pin_b_select,
   input wire logic node_address_compare,
   input wire rtdp_rx_evt_type rx_events,
   input wire logic fifo_wr_valid,
   output logic fifo_wr_ready,
   input wire logic [`RTDP_BYTE_W-1:0] fifo_wr_data,
   input wire logic overrun_clear,
   output rtdp_fifo_stat_type fifo_status,
   output logic tx_stopped_flag,
   input wire logic modulator_bit_clock,
   input wire logic tx_data_pin,
   output logic modulator_data,
   output logic modulator_active,
   output logic event_pin_a,
   output logic event_pin_b,
   input wire logic [`RTDP_DIV_W-1:0] ref_out_divider_field,
   input wire logic ref_out_enable_bit,
   output logic ref_out,
   output logic ref_out_oe
);
   localparam int LW = $clog2(DEPTH+1);
   localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);
   // Level and threshold meet at the wider width so neither is cut.
   localparam int CW = (LW > `RTDP_THRESH_W) ? LW : `RTDP_THRESH_W;

   rtdp_mode_type mode;
   rtdp_tx_state_type state_ff;
   rtdp_tx_state_type nxt_state;
   logic [LW-1:0] level;
   logic fifo_out_valid;
   logic [`RTDP_BYTE_W-1:0] fifo_out_data;
   logic fifo_pop;
   logic overrun_ff;
   logic clk_s1_ff, clk_s2_ff, clk_s3_ff;
   logic dat_s1_ff, dat_s2_ff;
   logic bit_tick;
   logic [`RTDP_BYTE_W-1:0] shreg_ff;
   logic [`RTDP_BITS_W-1:0] bits_left_ff;
   logic [`RTDP_LEN_W-1:0] cnt_ff;
   logic [`RTDP_LEN_W-1:0] nxt_cnt;
   logic [`RTDP_LEN_W-1:0] pay_len_ff;
   logic load;
   logic have_byte;
   logic [`RTDP_BYTE_W-1:0] load_byte;
   logic more_coming;
   logic start_ok;
   logic mod_bit_ff;
   logic tx_stopped_ff;
   logic nxt_pin_a, nxt_pin_b, pin_a_ff, pin_b_ff;
   logic [`RTDP_DIV_W-1:0] div_cnt_ff;
   logic ref_ff;
   logic ref_run;

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   always_comb begin
      if (!data_mode_select_bit) begin
         mode = RTDP_MODE_CONT; // [R1]
      end else if (packet_handler_enable_bit) begin
         mode = RTDP_MODE_PACKET; // [R19]
      end else begin
         mode = RTDP_MODE_BUFFERED;
      end
   end

   // ------------------------------------------------------------
   // FIFO and flags
   // ------------------------------------------------------------
   rtdp_fifo #(.WIDTH(`RTDP_BYTE_W), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .flush(overrun_clear), // [R7]
      .in_valid(fifo_wr_valid), // [R3]
      .in_ready(fifo_wr_ready),
      .in_force(1'b1), // [R6]
      .in_data(fifo_wr_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data),
      .level(level)
   );

   // Overrun is sticky; a new overrun in the clearing cycle wins.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overrun_ff <= 1'b0;
      end else if (fifo_wr_valid && !fifo_wr_ready) begin
         overrun_ff <= 1'b1; // [R6]
      end else if (overrun_clear) begin
         overrun_ff <= 1'b0; // [R7]
      end
   end

   always_comb begin
      fifo_status.fifo_full_flag = (level == FULL_LVL); // [R5]
      fifo_status.fifo_not_empty_flag = (level != '0); // [R8]
      fifo_status.fifo_overrun_flag = overrun_ff;
      fifo_status.tx_level_low =
         (CW'(level) <= CW'(fifo_level_threshold)); // [R24]
      fifo_status.rx_level_high =
         (CW'(level) >= CW'(fifo_level_threshold));
   end

   // ------------------------------------------------------------
   // Bit clock and continuous data synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_s1_ff <= 1'b0;
         clk_s2_ff <= 1'b0;
         clk_s3_ff <= 1'b0;
         dat_s1_ff <= 1'b0;
         dat_s2_ff <= 1'b0;
      end else begin
         clk_s1_ff <= modulator_bit_clock;
         clk_s2_ff <= clk_s1_ff;
         clk_s3_ff <= clk_s2_ff;
         dat_s1_ff <= tx_data_pin;
         dat_s2_ff <= dat_s1_ff;
      end
   end

   assign bit_tick = clk_s2_ff && !clk_s3_ff;

   // ------------------------------------------------------------
   // Framing sequencer
   // ------------------------------------------------------------
   always_comb begin
      if (tx_start_condition_bit) begin
         start_ok = fifo_out_valid; // [R4] [R23]
      end else begin
         start_ok = fifo_out_valid &&
                    (CW'(level) >= CW'(fifo_level_threshold));
      end
   end

   // Byte offered to the shifter by the current frame field.
   always_comb begin
      have_byte = 1'b0;
      load_byte = fifo_out_data;
      case (state_ff)
         RTDP_TX_WAIT: begin
            have_byte = (mode == RTDP_MODE_PACKET);
            load_byte = `RTDP_PREAMBLE_BYTE;
         end
         RTDP_TX_PREAMBLE: begin
            have_byte = 1'b1;
            load_byte = `RTDP_PREAMBLE_BYTE;
         end
         RTDP_TX_PATTERN: begin
            have_byte = 1'b1;
            load_byte = cnt_ff[0] ? start_pattern_word[7:0] :
                        start_pattern_word[15:8];
         end
         RTDP_TX_PAYLOAD: begin
            have_byte = fifo_out_valid;
         end
         RTDP_TX_CRC: begin
            have_byte = 1'b1;
            load_byte = cnt_ff[0] ? crc_word[7:0] : crc_word[15:8];
         end
         default: begin
            have_byte = 1'b0;
         end
      endcase
   end

   assign load = tx_mode && (mode != RTDP_MODE_CONT) && bit_tick &&
                 (bits_left_ff == '0) && have_byte;
   assign fifo_pop = load && (state_ff == RTDP_TX_PAYLOAD); // [R3] [R8]

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      case (state_ff)
         RTDP_TX_IDLE: begin
            nxt_state = RTDP_TX_WAIT;
            nxt_cnt = '0;
         end
         RTDP_TX_WAIT: begin
            if (start_ok) begin
               nxt_state = (mode == RTDP_MODE_PACKET) ? RTDP_TX_PREAMBLE :
                           RTDP_TX_PAYLOAD;
               nxt_cnt = '0;
            end
         end
         RTDP_TX_PREAMBLE: begin
            if (load) begin
               nxt_cnt = cnt_ff + 1'b1;
               if (cnt_ff == `RTDP_LEN_W'(preamble_len_field)) begin
                  nxt_state = RTDP_TX_PATTERN; // [R22]
                  nxt_cnt = '0;
               end
            end
         end
         RTDP_TX_PATTERN: begin
            if (load) begin
               nxt_cnt = cnt_ff + 1'b1;
               if (nxt_cnt == `RTDP_PATTERN_BYTES) begin
                  nxt_state = RTDP_TX_PAYLOAD; // [R22]
                  nxt_cnt = '0;
               end
            end
         end
         RTDP_TX_PAYLOAD: begin
            if (load && (mode == RTDP_MODE_PACKET)) begin
               nxt_cnt = cnt_ff + 1'b1;
               if (nxt_cnt == pay_len_ff) begin // [R21]
                  nxt_state = crc_enable_bit ? RTDP_TX_CRC : RTDP_TX_DRAIN;
                  nxt_cnt = '0;
               end
            end
         end
         RTDP_TX_CRC: begin
            if (load) begin
               nxt_cnt = cnt_ff + 1'b1;
               if (nxt_cnt == `RTDP_CRC_BYTES) begin
                  nxt_state = RTDP_TX_DRAIN; // [R22]
                  nxt_cnt = '0;
               end
            end
         end
         default: begin
            nxt_state = state_ff;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= RTDP_TX_IDLE;
         cnt_ff <= '0;
      end else if (!tx_mode || mode == RTDP_MODE_CONT) begin
         state_ff <= RTDP_TX_IDLE; // [R11]
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Fixed length comes from the field; variable length from first byte.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pay_len_ff <= '0;
      end else if (state_ff != RTDP_TX_PAYLOAD) begin
         pay_len_ff <= payload_length_field; // [R20] [R21]
      end else if (fifo_pop && cnt_ff == '0 && packet_length_format_bit) begin
         pay_len_ff <= fifo_out_data[`RTDP_LEN_W-1:0] + 1'b1; // [R20]
      end
   end

   // ------------------------------------------------------------
   // Bit shifter and modulator output
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shreg_ff <= '0;
         bits_left_ff <= '0;
         mod_bit_ff <= 1'b0;
      end else if (!tx_mode) begin
         shreg_ff <= '0; // [R11]
         bits_left_ff <= '0;
         mod_bit_ff <= 1'b0;
      end else if (bit_tick && mode == RTDP_MODE_CONT) begin
         mod_bit_ff <= dat_s2_ff; // [R1]
      end else if (load) begin
         mod_bit_ff <= load_byte[`RTDP_BYTE_W-1]; // [R25]
         shreg_ff <= {load_byte[`RTDP_BYTE_W-2:0], 1'b0};
         bits_left_ff <= `RTDP_LAST_BIT_IDX;
      end else if (bit_tick && bits_left_ff != '0) begin
         mod_bit_ff <= shreg_ff[`RTDP_BYTE_W-1]; // [R25]
         shreg_ff <= {shreg_ff[`RTDP_BYTE_W-2:0], 1'b0};
         bits_left_ff <= bits_left_ff - 1'b1;
      end
   end

   assign modulator_data = mod_bit_ff;
   assign modulator_active = tx_mode;

   // ------------------------------------------------------------
   // Transmit-stopped flag
   // ------------------------------------------------------------
   assign more_coming = (state_ff == RTDP_TX_PAYLOAD && fifo_out_valid) ||
                        (state_ff == RTDP_TX_WAIT &&
                         mode == RTDP_MODE_PACKET) ||
                        state_ff == RTDP_TX_PREAMBLE ||
                        state_ff == RTDP_TX_PATTERN ||
                        state_ff == RTDP_TX_CRC;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_stopped_ff <= 1'b0;
      end else if (!tx_mode) begin
         tx_stopped_ff <= 1'b0;
      end else if (bit_tick && bits_left_ff == `RTDP_BITS_W'(1) &&
                   !more_coming) begin
         tx_stopped_ff <= 1'b1; // [R9] [R10]
      end else if (load) begin
         tx_stopped_ff <= 1'b0;
      end
   end

   assign tx_stopped_flag = tx_stopped_ff;

   // ------------------------------------------------------------
   // Event pin multiplexers
   // ------------------------------------------------------------
   always_comb begin
      nxt_pin_a = 1'b0;
      nxt_pin_b = 1'b0;
      if (tx_mode) begin
         if (mode == RTDP_MODE_CONT) begin
            nxt_pin_a = 1'b0; // [R13]
            nxt_pin_b = clk_s2_ff; // [R1] [R12]
         end else begin
            nxt_pin_a = tx_pin_a_select ? fifo_status.fifo_not_empty_flag :
                        fifo_status.tx_level_low; // [R13]
            nxt_pin_b = tx_pin_b_select ? tx_stopped_ff :
                        fifo_status.fifo_full_flag; // [R5] [R12]
         end
      end else if (rx_mode) begin
         if (mode == RTDP_MODE_CONT) begin
            nxt_pin_b = clk_s2_ff; // [R15]
            if (rx_pin_a_select == `RTDP_SEL_01) begin
               nxt_pin_a = rx_events.signal_level_event; // [R14]
            end else begin
               nxt_pin_a = rx_events.pattern_match;
            end
         end else begin
            if (rx_pin_a_select == `RTDP_SEL_00) begin
               nxt_pin_a = (mode == RTDP_MODE_PACKET) &&
                           rx_events.payload_ready; // [R14]
            end else if (rx_pin_a_select == `RTDP_SEL_01) begin
               nxt_pin_a = rx_events.byte_written;
            end else if (rx_pin_a_select == `RTDP_SEL_10) begin
               nxt_pin_a = fifo_status.fifo_not_empty_flag;
            end else if (mode == RTDP_MODE_PACKET && node_address_compare) begin
               nxt_pin_a = rx_events.node_address_match;
            end else begin
               nxt_pin_a = rx_events.pattern_match;
            end
            if (rx_pin_b_select == `RTDP_SEL_00) begin
               nxt_pin_b = (mode == RTDP_MODE_PACKET) &&
                           rx_events.crc_ok; // [R15]
            end else if (rx_pin_b_select == `RTDP_SEL_01) begin
               nxt_pin_b = fifo_status.fifo_full_flag;
            end else if (rx_pin_b_select == `RTDP_SEL_10) begin
               nxt_pin_b = rx_events.signal_level_event;
            end else begin
               nxt_pin_b = fifo_status.rx_level_high;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_a_ff <= 1'b0;
         pin_b_ff <= 1'b0;
      end else begin
         pin_a_ff <= nxt_pin_a;
         pin_b_ff <= nxt_pin_b;
      end
   end

   assign event_pin_a = pin_a_ff;
   assign event_pin_b = pin_b_ff;

   // ------------------------------------------------------------
   // Divided reference clock output
   // ------------------------------------------------------------
   assign ref_run = ref_out_enable_bit && !sleep_mode; // [R16] [R18]

   // Output toggles every divider field plus one cycles of the clock.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_cnt_ff <= '0;
         ref_ff <= 1'b0;
      end else if (!ref_run) begin
         div_cnt_ff <= '0; // [R18]
         ref_ff <= 1'b0;
      end else if (div_cnt_ff >= ref_out_divider_field) begin
         div_cnt_ff <= '0; // [R17]
         ref_ff <= !ref_ff;
      end else begin
         div_cnt_ff <= div_cnt_ff + 1'b1;
      end
   end

   assign ref_out = ref_ff;
   assign ref_out_oe = ref_run; // [R16]
endmodule

//--- rtl/rtdp_params.svh
// Constants for the transmit datapath and event pin multiplexer.
`ifndef RTDP_PARAMS_SVH
`define RTDP_PARAMS_SVH

`define RTDP_FIFO_DEPTH 64
`define RTDP_BYTE_W 8
`define RTDP_LEN_W 7
`define RTDP_THRESH_W 6
`define RTDP_DIV_W 5
`define RTDP_BITS_W 3
`define RTDP_LAST_BIT_IDX 3'h7
`define RTDP_PREAMBLE_BYTE 8'haa
`define RTDP_PATTERN_BYTES 7'h02
`define RTDP_CRC_BYTES 7'h02
`define RTDP_SEL_00 2'h0
`define RTDP_SEL_01 2'h1
`define RTDP_SEL_10 2'h2
`define RTDP_SEL_11 2'h3

`endif

//--- rtl/rtdp_pkg.sv
// Types shared by the transmit datapath and event pin multiplexer.
package rtdp_pkg;

   typedef enum logic [1:0] {
      RTDP_MODE_CONT,
      RTDP_MODE_BUFFERED,
      RTDP_MODE_PACKET
   } rtdp_mode_type;

   typedef enum logic [2:0] {
      RTDP_TX_IDLE,
      RTDP_TX_WAIT,
      RTDP_TX_PREAMBLE,
      RTDP_TX_PATTERN,
      RTDP_TX_PAYLOAD,
      RTDP_TX_CRC,
      RTDP_TX_DRAIN
   } rtdp_tx_state_type;

   typedef struct packed {
      logic pattern_match;
      logic signal_level_event;
      logic byte_written;
      logic payload_ready;
      logic node_address_match;
      logic crc_ok;
   } rtdp_rx_evt_type;

   typedef struct packed {
      logic fifo_full_flag;
      logic fifo_not_empty_flag;
      logic fifo_overrun_flag;
      logic tx_level_low;
      logic rx_level_high;
   } rtdp_fifo_stat_type;

endpackage

//--- tb/rtdp_datapath_tb.sv
// Self-checking bench for the transmit datapath.
module rtdp_datapath_tb
   import rtdp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, tx_mode, rx_mode, sleep_mode, data_mode_select_bit;
   logic packet_handler_enable_bit, packet_length_format_bit, crc_enable_bit;
   logic tx_start_condition_bit, tx_pin_a_select, tx_pin_b_select, cont_bit;
   logic node_address_compare, fifo_wr_valid, overrun_clear, ref_out;
   logic ref_out_enable_bit, fifo_wr_ready, tx_stopped_flag, modulator_data;
   logic modulator_active, event_pin_a, event_pin_b, ref_out_oe;
   logic modulator_bit_clock, tx_data_pin;
   logic [1:0] preamble_len_field, rx_pin_a_select, rx_pin_b_select;
   logic [15:0] start_pattern_word, crc_word;
   logic [6:0] payload_length_field;
   logic [5:0] fifo_level_threshold;
   logic [7:0] fifo_wr_data;
   logic [4:0] ref_out_divider_field;
   logic [31:0] seen;
   rtdp_rx_evt_type rx_events;
   rtdp_fifo_stat_type fifo_status;
   int num_errors = 0;
   int compares = 0;
   time t0;
   rtdp_datapath #(.DEPTH(8)) u_rtdp_datapath (.*);
   rtdp_host_model u_rtdp_host_model (.*);
   initial clk = 1'b0;
   always #5 clk = ~clk;
   always @(posedge modulator_bit_clock) seen <= {seen[30:0], modulator_data};

   task automatic chk(input string what, input logic [31:0] got, exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] b);
      @(negedge clk);
      fifo_wr_valid = 1'b1;
      fifo_wr_data = b;
      @(negedge clk);
      fifo_wr_valid = 1'b0;
   endtask

   task automatic tx_run(input string what, input logic [31:0] exp);
      for (int n = 0; n < 3000 && tx_stopped_flag !== 1'b1; n++) begin
         @(negedge clk);
      end
      @(negedge clk);
      chk("stop", 32'({modulator_active, fifo_status.fifo_not_empty_flag,
         event_pin_b}), 32'h5);
      // The host stays in transmit one more bit period.
      @(posedge modulator_bit_clock);
      repeat (4) @(negedge clk);
      chk(what, seen, exp);
      tx_mode = 1'b0;
      @(negedge clk);
      @(negedge clk);
      chk("left tx", 32'({tx_stopped_flag, modulator_active}),
         32'h0);
   endtask

   task automatic give_verdict();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      num_errors++;
      give_verdict();
   end

   initial begin
      {tx_mode, rx_mode, sleep_mode, data_mode_select_bit, cont_bit,
       packet_handler_enable_bit, packet_length_format_bit, crc_enable_bit,
       tx_start_condition_bit, tx_pin_a_select, tx_pin_b_select, rx_events,
       node_address_compare, fifo_wr_valid, overrun_clear, ref_out_enable_bit,
       payload_length_field, preamble_len_field, rx_pin_a_select, crc_word,
       rx_pin_b_select, start_pattern_word, fifo_level_threshold,
       fifo_wr_data, ref_out_divider_field} = '0;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk("reset", 32'({fifo_wr_ready, ref_out_oe}), 32'h2);
      $display("reset test done");
      data_mode_select_bit = 1'b1;
      tx_mode = 1'b1;
      fifo_level_threshold = 6'h10;
      for (int i = 0; i < 9; i++) begin
         wr(8'(i));
      end
      @(negedge clk);
      chk("fifo", 32'({fifo_status.fifo_full_flag, event_pin_b,
         fifo_status.fifo_overrun_flag, fifo_status.tx_level_low,
         fifo_status.rx_level_high}), 32'h1e);
      tx_mode = 1'b0;
      rx_mode = 1'b1;
      rx_pin_b_select = 2'h1;
      rx_pin_a_select = 2'h2;
      @(negedge clk);
      @(negedge clk);
      chk("rx pins", 32'({event_pin_a, event_pin_b}), 32'h3);
      rx_mode = 1'b0;
      overrun_clear = 1'b1;
      @(negedge clk);
      overrun_clear = 1'b0;
      chk("clear", 32'({fifo_status.fifo_overrun_flag,
         fifo_status.fifo_not_empty_flag}), 32'h0);
      $display("fifo test done");
      tx_start_condition_bit = 1'b0;
      fifo_level_threshold = 6'h4;
      tx_pin_b_select = 1'b1;
      tx_mode = 1'b1;
      wr(8'hb4);
      wr(8'h3c);
      wr(8'h96);
      repeat (30) @(negedge clk);
      chk("held", 32'(seen[3:0]), 32'h0);
      wr(8'he1);
      tx_run("buffered", 32'hb43c96e1);
      $display("buffered test done");
      packet_handler_enable_bit = 1'b1;
      tx_start_condition_bit = 1'b1;
      tx_pin_a_select = 1'b1;
      payload_length_field = 7'h1;
      start_pattern_word = 16'h2dd4;
      tx_mode = 1'b1;
      wr(8'h5a);
      tx_run("packet", 32'haa2dd45a);
      $display("packet test done");
      data_mode_select_bit = 1'b0;
      cont_bit = 1'b1;
      tx_mode = 1'b1;
      repeat (6) @(posedge modulator_bit_clock);
      repeat (3) @(negedge clk);
      chk("cont", 32'({seen[3:0], event_pin_a, event_pin_b}),
         32'h3d);
      tx_mode = 1'b0;
      $display("continuous test done");
      ref_out_divider_field = 5'h2;
      ref_out_enable_bit = 1'b1;
      @(posedge ref_out);
      t0 = $time;
      @(posedge ref_out);
      chk("ref period", 32'($time - t0), 32'h3c);
      @(negedge clk);
      sleep_mode = 1'b1;
      @(negedge clk);
      @(negedge clk);
      chk("ref sleep", 32'({ref_out_oe, ref_out}), 32'h0);
      $display("ref test done");
      give_verdict();
   end
endmodule

//--- tb/rtdp_host_model.sv
// Modulator-side bit clock and host continuous data source.
module rtdp_host_model (
   output logic modulator_bit_clock,
   output logic tx_data_pin,
   input wire logic cont_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   initial tx_data_pin = 1'b0;
   // Offset so bit clock edges never share a time step with clk edges.
   initial begin
      modulator_bit_clock = 1'b0;
      #2;
      forever #40 modulator_bit_clock = ~modulator_bit_clock;
   end
   // Data moves on the falling edge, away from the sampling rise.
   always @(negedge modulator_bit_clock) tx_data_pin <= cont_bit;
endmodule

//--- tb/rtdp_props.sv
// Concurrent checks on the ports of the transmit datapath.
module rtdp_props
   import rtdp_pkg::*;
#(
   parameter int DEPTH = 64
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tx_mode,
   input wire logic sleep_mode,
   input wire logic data_mode_select_bit,
   input wire logic tx_pin_a_select,
   input wire logic tx_pin_b_select,
   input wire logic fifo_wr_valid,
   input wire logic fifo_wr_ready,
   input wire logic overrun_clear,
   input wire rtdp_fifo_stat_type fifo_status,
   input wire logic tx_stopped_flag,
   input wire logic event_pin_a,
   input wire logic event_pin_b,
   input wire logic ref_out_enable_bit,
   input wire logic ref_out_oe
);
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_ref_oe;
      ref_out_oe == (ref_out_enable_bit && !sleep_mode);
   endproperty
   a_ref_oe: assert property (p_ref_oe) else $error("ref oe");
   property p_full;
      fifo_status.fifo_full_flag != fifo_wr_ready;
   endproperty
   a_full: assert property (p_full) else $error("full vs ready");
   property p_ovr_set;
      fifo_wr_valid && !fifo_wr_ready |=> fifo_status.fifo_overrun_flag;
   endproperty
   a_ovr_set: assert property (p_ovr_set) else $error("ovr set");
   property p_ovr_clr;
      overrun_clear && !fifo_wr_valid |=> !fifo_status.fifo_overrun_flag
         && !fifo_status.fifo_not_empty_flag;
   endproperty
   a_ovr_clr: assert property (p_ovr_clr) else $error("ovr clr");
   property p_pin_b;
      tx_mode && data_mode_select_bit |=> event_pin_b == ($past(
         tx_pin_b_select) ? $past(tx_stopped_flag) :
         $past(fifo_status.fifo_full_flag));
   endproperty
   a_pin_b: assert property (p_pin_b) else $error("pin b");
   property p_pin_a_cont;
      tx_mode && !data_mode_select_bit |=> !event_pin_a;
   endproperty
   a_pin_a_cont: assert property (p_pin_a_cont) else $error("a cont");
   property p_pin_a_buf;
      tx_mode && data_mode_select_bit |=> event_pin_a == ($past(
         tx_pin_a_select) ? $past(fifo_status.fifo_not_empty_flag) :
         $past(fifo_status.tx_level_low));
   endproperty
   a_pin_a_buf: assert property (p_pin_a_buf) else $error("a");
   property p_leave;
      !tx_mode |=> !tx_stopped_flag;
   endproperty
   a_leave: assert property (p_leave) else $error("leave tx");
endmodule

bind rtdp_datapath rtdp_props #(.DEPTH(DEPTH)) u_rtdp_props (.*);
